// ===== sbs_host.sv
// Host model driving the single control line
`timescale 1ns/1ps
module sbs_host (
    // Clock and line
    input  wire logic clock_in,
    output logic      ctrl_out
);
    initial ctrl_out = 1'b0;
    // Rises two cycles apart; last pulse may stay high, no rise in blank
    task automatic cmd(input int n, input logic hold);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clock_in) ctrl_out <= 1'b1;
            @(posedge clock_in) ctrl_out <= (i == n - 1) ? hold : 1'b0;
        end
    endtask
    task automatic level(input logic v, input int c);
        @(posedge clock_in) ctrl_out <= v;
        repeat (c) @(posedge clock_in);
    endtask
endmodule

// ===== sbs_mem.sv
// Small interval store with registered read data
`timescale 1ns/1ps
module sbs_mem #(
    parameter int DEPTH = 6,
    parameter int WIDTH = 8,
    parameter int AW    = 3
) (
    // Clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    // Write port
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    // Read port
    input  wire logic [AW-1:0]    rd_addr_in,
    output logic      [WIDTH-1:0] rd_data_out
);

    initial begin
        if (DEPTH < 1 || DEPTH > (1 << AW))
            $error("sbs_mem: DEPTH does not fit AW");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];

    // Cleared on reset so a power-up never replays stale intervals
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= '0;
            rd_data_out <= '0;
        end
        else
        begin
            if (wr_en_in && (int'(wr_addr_in) < DEPTH))
                mem_q[wr_addr_in] <= wr_data_in;
            rd_data_out <= (int'(rd_addr_in) < DEPTH) ? mem_q[rd_addr_in] : '0;
        end
    end

endmodule

// ===== sbs_pkg.sv
// Shared constants, types and command decoding for the blink sequencer
package sbs_pkg;

    // Time base and window timing
    localparam int CLK_MHZ     = 10;
    localparam int ENTER_US    = 500;
    localparam int BLANK_US    = 500;
    localparam int ON_UNIT_US  = 1000;
    localparam int OFF_UNIT_US = 10000;
    localparam int ENTER_CYC   = ENTER_US * CLK_MHZ;
    localparam int BLANK_CYC   = BLANK_US * CLK_MHZ;
    localparam int ON_CYC      = ON_UNIT_US * CLK_MHZ;
    localparam int OFF_CYC     = OFF_UNIT_US * CLK_MHZ;
    localparam int SUM_MAX_US  = 1500;
    localparam int TMR_W       = 20;

    // Sequence storage
    localparam int             IVL_W     = 8;
    localparam int             MAX_PAIRS = 3;
    localparam int             MEM_DEPTH = 2 * MAX_PAIRS;
    localparam int             MEM_AW    = 3;
    localparam logic [7:0]     IVL_SAT   = 8'hFF;
    localparam logic [7:0]     IVL_NEAR  = 8'hFE;
    localparam logic [7:0]     IVL_MIN   = 8'h01;
    localparam logic [2:0]     EDGE_MAX  = 3'h7;

    typedef enum logic [2:0] {
        CMD_NONE   = 3'h0,
        CMD_RUN    = 3'h1,
        CMD_TSTART = 3'h2,
        CMD_TEND   = 3'h3,
        CMD_ONCE   = 3'h4
    } sbs_cmd_t;

    typedef enum logic [3:0] {
        ST_STANDBY  = 4'h0,
        ST_ENTER    = 4'h1,
        ST_BLANK    = 4'h3,
        ST_WAIT_HI  = 4'h2,
        ST_RUN_DIR  = 4'h6,
        ST_PLAY_FET = 4'h7,
        ST_PLAY_LD  = 4'h5,
        ST_PLAY_RUN = 4'h4,
        ST_TR_WAIT  = 4'hC,
        ST_TR_ON    = 4'hD,
        ST_TR_OFF   = 4'hF,
        ST_WAIT_LO  = 4'hE
    } sbs_state_t;

    // Edge count to command
    function automatic sbs_cmd_t sbs_decode(input logic [2:0] edges);
        case (edges)
            3'h1:    return CMD_RUN;
            3'h2:    return CMD_TSTART;
            3'h3:    return CMD_TEND;
            3'h4:    return CMD_ONCE;
            default: return CMD_NONE;
        endcase
    endfunction

endpackage

// ===== sbs_top.sv
// Single-wire blink sequencer: command decode, training and playback
// How it works
// - Reset turns everything off and clears state and stored sequence.
// - After reset the block idles in standby until the line moves.
// - A rising edge in standby wakes the block and opens the entry window.
// - Every rising edge inside the entry window is counted, up to seven.
// - One edge run, two training start, three training end, four run once.
// - Line high at blank end: run and run once start right after blank.
// - Line low at blank end: run once and training start wait for the line to rise.
// - Run without a sequence copies the line onto the LED.
// - Run with a sequence plays it repeatedly while the line stays high.
// - Both run forms go to standby when the line falls.
// - Run once plays one pass then standby; needs a stored sequence.
// - Line falling during run once aborts playback into standby.
// - Thermal shutdown forces the LED off, logic keeps running.
// - Storage is volatile; start then end without intervals clears it.
// - Training measures first on time from first rising edge, LED mirrors line.
// - Falling line stores the on time and starts off measurement.
// - One to three pairs; valid only with a full on and off.
// - Entry window at least 500 us, window plus blank at most 1500 us.
// - On times count in 1 ms units, off times in 10 ms units.
// - Training end during off measurement stores it and goes standby.
// - On counter saturating stores maximum, LED off, off measurement begins.
`timescale 1ns/1ps
module sbs_top
    import sbs_pkg::*;
#(
    parameter int ENTER_CYCLES = ENTER_CYC,
    parameter int BLANK_CYCLES = BLANK_CYC,
    parameter int ON_CYCLES    = ON_CYC,
    parameter int OFF_CYCLES   = OFF_CYC
) (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // Control line and thermal sense
    input  wire logic       ctrl_in,
    input  wire logic       thermal_shutdown_in,
    // LED drive and status
    output logic            led_out,
    output logic            active_out,
    output logic [1:0]      seq_len_out
);

    initial begin
        if (ENTER_CYCLES < 2 || BLANK_CYCLES < 2 || ON_CYCLES < 2 || OFF_CYCLES < 2)
            $error("sbs_top: timing counts must be at least 2");
        if (ENTER_CYCLES >= (1 << TMR_W) || BLANK_CYCLES >= (1 << TMR_W) ||
            ON_CYCLES >= (1 << TMR_W) || OFF_CYCLES >= (1 << TMR_W))
            $error("sbs_top: timing count too wide for timer");
    end

    // Memory address of one interval: pair index, then on or off
    function automatic logic [MEM_AW-1:0] addr_of(input logic [1:0] idx, input logic off);
        return {idx, off};
    endfunction

    sbs_state_t         state_q;
    sbs_cmd_t           cmd_q;
    logic               ctrl_q;
    logic [TMR_W-1:0]   win_q;
    logic               win_open_q;
    logic [2:0]         edges_q;
    logic [TMR_W-1:0]   presc_q;
    logic [IVL_W-1:0]   unit_q;
    logic [1:0]         pairs_q;
    logic               on_rec_q;
    logic [1:0]         seq_len_q;
    logic [1:0]         idx_q;
    logic               phase_off_q;
    logic               once_q;
    logic [IVL_W-1:0]   dur_q;
    logic               wr_en_q;
    logic [MEM_AW-1:0]  wr_addr_q;
    logic [IVL_W-1:0]   wr_data_q;
    logic               active_q;
    logic               led_q;
    logic [IVL_W-1:0]   rd_data;

    // Edge detection; the line is already synchronous to clock_in
    wire rise = ctrl_in & ~ctrl_q;
    wire fall = ~ctrl_in & ctrl_q;

    wire       playing    = (state_q == ST_PLAY_FET) || (state_q == ST_PLAY_LD) ||
                            (state_q == ST_PLAY_RUN);
    wire       off_phase  = (state_q == ST_TR_OFF) || (playing && phase_off_q);
    wire [TMR_W-1:0] unit_len = off_phase ? TMR_W'(OFF_CYCLES - 1)
                                          : TMR_W'(ON_CYCLES - 1);
    wire       tick       = (presc_q == unit_len);
    wire       win_end    = win_open_q && (win_q == TMR_W'(ENTER_CYCLES - 1));
    wire       blank_end  = (state_q == ST_BLANK) &&
                            (win_q == TMR_W'(BLANK_CYCLES - 1));
    wire [2:0] edges_next = (rise && edges_q != EDGE_MAX) ? edges_q + 3'h1 : edges_q;
    wire sbs_cmd_t cmd_dec = sbs_decode(edges_next);
    wire [IVL_W-1:0] unit_val = (unit_q == '0) ? IVL_MIN : unit_q;
    wire       phase_done = tick && (unit_q == dur_q - IVL_MIN);
    wire       on_sat     = (state_q == ST_TR_ON) && !win_open_q && tick &&
                            (unit_q == IVL_NEAR);
    wire       last_pair  = ({1'b0, idx_q} + 3'h1) == {1'b0, seq_len_q};
    wire [MEM_AW-1:0] rd_addr = addr_of(idx_q, phase_off_q);

    // LED follows the line in direct run and while an on time is captured
    wire led_d = (state_q == ST_RUN_DIR) ? ctrl_in :
                 (state_q == ST_TR_ON)   ? ctrl_in :
                 playing                 ? ~phase_off_q : 1'b0;

    sbs_mem #(
        .DEPTH (MEM_DEPTH),
        .WIDTH (IVL_W),
        .AW    (MEM_AW)
    ) u_mem (
        .clock_in    (clock_in),
        .rst_n_in    (rst_n_in),
        .wr_en_in    (wr_en_q),
        .wr_addr_in  (wr_addr_q),
        .wr_data_in  (wr_data_q),
        .rd_addr_in  (rd_addr),
        .rd_data_out (rd_data)
    );

    // Output stage; thermal shutdown only gates the driver
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            led_q    <= 1'b0;
            active_q <= 1'b0;
        end
        else
        begin
            led_q    <= led_d & ~thermal_shutdown_in;
            active_q <= (state_q != ST_STANDBY);
        end
    end

    assign led_out     = led_q;
    assign active_out  = active_q;
    assign seq_len_out = seq_len_q;

    // Unit divider: restarted at every measured or played interval
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            presc_q <= '0;
            unit_q  <= '0;
        end
        // Off count starts at on saturation; a later fall must not restart it
        else if (rise || (fall && state_q != ST_TR_OFF) || on_sat ||
                 state_q == ST_PLAY_LD || state_q == ST_TR_WAIT)
        begin
            presc_q <= '0;
            unit_q  <= '0;
        end
        else if (tick)
        begin
            presc_q <= '0;
            unit_q  <= (unit_q == IVL_SAT) ? IVL_SAT : unit_q + IVL_MIN;
        end
        else
            presc_q <= presc_q + TMR_W'(1);
    end

    // Main sequencer
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            state_q     <= ST_STANDBY;
            cmd_q       <= CMD_NONE;
            ctrl_q      <= 1'b0;
            win_q       <= '0;
            win_open_q  <= 1'b0;
            edges_q     <= 3'h0;
            pairs_q     <= 2'h0;
            on_rec_q    <= 1'b0;
            seq_len_q   <= 2'h0;
            idx_q       <= 2'h0;
            phase_off_q <= 1'b0;
            once_q      <= 1'b0;
            dur_q       <= '0;
            wr_en_q     <= 1'b0;
            wr_addr_q   <= '0;
            wr_data_q   <= '0;
        end
        else
        begin
            ctrl_q  <= ctrl_in;
            wr_en_q <= 1'b0;
            if (win_open_q || state_q == ST_BLANK)
                win_q <= win_q + TMR_W'(1);
            case (state_q)
                ST_STANDBY:
                begin
                    if (rise)
                    begin
                        state_q    <= ST_ENTER;
                        edges_q    <= 3'h1;
                        win_q      <= '0;
                        win_open_q <= 1'b1;
                    end
                end
                ST_ENTER:
                begin
                    edges_q <= edges_next;
                    if (win_end)
                    begin
                        state_q    <= ST_BLANK;
                        cmd_q      <= cmd_dec;
                        win_q      <= '0;
                        win_open_q <= 1'b0;
                    end
                end
                ST_BLANK:
                begin
                    // Edges here are ignored; the host keeps the blank quiet
                    if (blank_end)
                    begin
                        idx_q       <= 2'h0;
                        phase_off_q <= 1'b0;
                        case (cmd_q)
                            CMD_RUN:
                            begin
                                once_q <= 1'b0;
                                // Run needs the line held high
                                if (!ctrl_in)
                                    state_q <= ST_STANDBY;
                                else if (seq_len_q != 2'h0)
                                    state_q <= ST_PLAY_FET;
                                else
                                    state_q <= ST_RUN_DIR;
                            end
                            CMD_TSTART:
                            begin
                                pairs_q  <= 2'h0;
                                on_rec_q <= 1'b0;
                                state_q  <= ST_TR_WAIT;
                            end
                            CMD_ONCE:
                            begin
                                once_q <= 1'b1;
                                if (seq_len_q == 2'h0)
                                    state_q <= ST_STANDBY;
                                else if (ctrl_in)
                                    state_q <= ST_PLAY_FET;
                                else
                                    state_q <= ST_WAIT_HI;
                            end
                            default:
                                state_q <= ST_STANDBY;
                        endcase
                    end
                end
                ST_WAIT_HI:
                begin
                    if (rise)
                        state_q <= ST_PLAY_FET;
                end
                ST_RUN_DIR:
                begin
                    if (!ctrl_in)
                        state_q <= ST_STANDBY;
                end
                ST_PLAY_FET, ST_PLAY_LD, ST_PLAY_RUN:
                begin
                    if (!ctrl_in)
                        state_q <= ST_STANDBY;
                    else if (state_q == ST_PLAY_FET)
                        state_q <= ST_PLAY_LD;
                    else if (state_q == ST_PLAY_LD)
                    begin
                        dur_q   <= rd_data;
                        state_q <= ST_PLAY_RUN;
                    end
                    else if (phase_done)
                    begin
                        state_q     <= ST_PLAY_FET;
                        phase_off_q <= ~phase_off_q;
                        if (phase_off_q)
                        begin
                            idx_q <= last_pair ? 2'h0 : idx_q + 2'h1;
                            if (last_pair && once_q)
                                state_q <= ST_STANDBY;
                        end
                    end
                end
                ST_TR_WAIT:
                begin
                    if (rise)
                    begin
                        state_q    <= ST_TR_ON;
                        edges_q    <= 3'h1;
                        win_q      <= '0;
                        win_open_q <= 1'b1;
                    end
                end
                ST_TR_ON:
                begin
                    if (win_open_q)
                    begin
                        // A fresh on time may be a training end in disguise
                        edges_q <= edges_next;
                        if (win_end)
                        begin
                            win_open_q <= 1'b0;
                            if (cmd_dec == CMD_TEND)
                            begin
                                seq_len_q <= pairs_q;
                                state_q   <= ST_STANDBY;
                            end
                            else if (!ctrl_in)
                            begin
                                state_q   <= ST_TR_OFF;
                                on_rec_q  <= (pairs_q != 2'(MAX_PAIRS));
                                if (pairs_q != 2'(MAX_PAIRS))
                                begin
                                    wr_en_q   <= 1'b1;
                                    wr_addr_q <= addr_of(pairs_q, 1'b0);
                                    wr_data_q <= unit_val;
                                    pairs_q   <= pairs_q + 2'h1;
                                end
                            end
                        end
                    end
                    else if (fall || (tick && unit_q == IVL_NEAR))
                    begin
                        state_q  <= ST_TR_OFF;
                        on_rec_q <= (pairs_q != 2'(MAX_PAIRS));
                        if (pairs_q != 2'(MAX_PAIRS))
                        begin
                            wr_en_q   <= 1'b1;
                            wr_addr_q <= addr_of(pairs_q, 1'b0);
                            wr_data_q <= fall ? unit_val : IVL_SAT;
                            pairs_q   <= pairs_q + 2'h1;
                        end
                    end
                end
                ST_TR_OFF:
                begin
                    if (rise)
                    begin
                        state_q    <= ST_TR_ON;
                        edges_q    <= 3'h1;
                        win_q      <= '0;
                        win_open_q <= 1'b1;
                        // Off time is kept now; a training end keeps it too
                        wr_en_q    <= on_rec_q;
                        wr_addr_q  <= addr_of(pairs_q - 2'h1, 1'b1);
                        wr_data_q  <= unit_val;
                    end
                    else if (tick && unit_q == IVL_NEAR)
                    begin
                        wr_en_q   <= on_rec_q;
                        wr_addr_q <= addr_of(pairs_q - 2'h1, 1'b1);
                        wr_data_q <= IVL_SAT;
                        seq_len_q <= on_rec_q || pairs_q != 2'h0 ? pairs_q : 2'h0;
                        state_q   <= ST_WAIT_LO;
                    end
                end
                ST_WAIT_LO:
                begin
                    if (!ctrl_in)
                        state_q <= ST_STANDBY;
                end
                default:
                    state_q <= ST_STANDBY;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_blank_run_direct;
        blank_end && cmd_q == CMD_RUN && ctrl_in && seq_len_q == 2'h0;
    endsequence

    sequence s_train_end;
        state_q == ST_TR_ON && win_end && cmd_dec == CMD_TEND;
    endsequence

    a_reset_clears: assert property (disable iff (1'b0)
        !rst_n_in |=> state_q == ST_STANDBY && seq_len_q == 2'h0 && !led_out)
        else $error("reset did not clear state");
    a_thermal_led_off: assert property (
        thermal_shutdown_in |=> !led_out)
        else $error("LED on during thermal shutdown");
    a_rise_wakes: assert property (
        state_q == ST_STANDBY && rise |=> state_q == ST_ENTER && edges_q == 3'h1)
        else $error("rising edge did not open entry window");
    a_edge_count: assert property (
        state_q == ST_ENTER && rise && !win_end && edges_q != EDGE_MAX
        |=> edges_q == $past(edges_q) + 3'h1)
        else $error("entry edge not counted");
    a_window_length: assert property (
        state_q == ST_ENTER |-> win_q < TMR_W'(ENTER_CYCLES))
        else $error("entry window overran");
    a_blank_direct_run: assert property (
        s_blank_run_direct |=> state_q == ST_RUN_DIR ##1 led_out == $past(ctrl_in)
                               || $past(thermal_shutdown_in) || state_q != ST_RUN_DIR)
        else $error("run did not start after blank");
    a_once_deferred: assert property (
        blank_end && cmd_q == CMD_ONCE && seq_len_q != 2'h0 && !ctrl_in
        |=> state_q == ST_WAIT_HI)
        else $error("run once not deferred");
    a_once_needs_seq: assert property (
        blank_end && cmd_q == CMD_ONCE && seq_len_q == 2'h0 |=> state_q == ST_STANDBY)
        else $error("run once honoured without sequence");
    a_fall_to_standby: assert property (
        (playing || state_q == ST_RUN_DIR) && !ctrl_in |=> state_q == ST_STANDBY)
        else $error("line low did not stop run");
    a_train_fall_store: assert property (
        state_q == ST_TR_ON && !win_open_q && fall && pairs_q != 2'h3
        |=> state_q == ST_TR_OFF && wr_en_q && !wr_addr_q[0])
        else $error("on time not stored on falling edge");
    a_train_end_commit: assert property (
        s_train_end |=> state_q == ST_STANDBY && seq_len_q == $past(pairs_q))
        else $error("training end did not commit");
    a_on_saturate: assert property (
        state_q == ST_TR_ON && !win_open_q && !fall && tick && unit_q == IVL_NEAR
        && pairs_q != 2'h3 |=> state_q == ST_TR_OFF && wr_data_q == IVL_SAT ##1 !led_out)
        else $error("on saturation not handled");

endmodule

// ===== tb.sv
// Testbench: commands, training, playback and thermal gating
`timescale 1ns/1ps
module tb;
    logic       clock_in;
    logic       rst_n_in;
    logic       ctrl_in;
    logic       thermal_shutdown_in;
    logic       led_out;
    logic       active_out;
    logic [1:0] seq_len_out;
    int         n_fail = 0;
    int         checked = 0;
    int         cycles = 0;
    sbs_host host_u (.clock_in(clock_in), .ctrl_out(ctrl_in));
    sbs_top #(.ENTER_CYCLES(20), .BLANK_CYCLES(20), .ON_CYCLES(10), .OFF_CYCLES(40)) dut_u (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .ctrl_in(ctrl_in),
        .thermal_shutdown_in(thermal_shutdown_in), .led_out(led_out),
        .active_out(active_out), .seq_len_out(seq_len_out));
    task automatic summarize();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Compares {active, led} or the stored pair count
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Settle past the edge so registered outputs have landed
    task automatic hold(input logic v, input int c);
        host_u.level(v, c);
        #10;
    endtask
    task automatic s_direct();
        host_u.cmd(1, 1'b1);
        hold(1'b1, 45);
        chk({active_out, led_out}, 2'h3);
        @(posedge clock_in) thermal_shutdown_in <= 1'b1;
        hold(1'b1, 3);
        chk({active_out, led_out}, 2'h2);
        @(posedge clock_in) thermal_shutdown_in <= 1'b0;
        hold(1'b0, 3);
        chk({active_out, led_out}, 2'h0);
        host_u.cmd(4, 1'b1);
        hold(1'b1, 45);
        chk({active_out, led_out}, 2'h0);
        hold(1'b0, 2);
    endtask
    task automatic s_train();
        host_u.cmd(2, 1'b0);
        hold(1'b0, 45);
        chk({active_out, led_out}, 2'h2);
        hold(1'b1, 35);
        chk({active_out, led_out}, 2'h3);
        hold(1'b0, 90);
        chk({active_out, led_out}, 2'h2);
        host_u.cmd(3, 1'b0);
        hold(1'b0, 45);
        chk({active_out, led_out}, 2'h0);
        chk(seq_len_out, 2'h1);
    endtask
    // Stored pair: 3 on units then 2 off units, each plus two fetch cycles
    task automatic s_play();
        host_u.cmd(1, 1'b1);
        hold(1'b1, 53);
        chk({active_out, led_out}, 2'h3);
        hold(1'b1, 60);
        chk({active_out, led_out}, 2'h2);
        hold(1'b1, 55);
        chk({active_out, led_out}, 2'h3);
        hold(1'b0, 3);
        chk({active_out, led_out}, 2'h0);
        host_u.cmd(4, 1'b1);
        hold(1'b1, 50);
        chk({active_out, led_out}, 2'h3);
        hold(1'b1, 110);
        chk({active_out, led_out}, 2'h0);
        hold(1'b0, 2);
        host_u.cmd(4, 1'b1);
        hold(1'b1, 50);
        chk({active_out, led_out}, 2'h3);
        hold(1'b0, 3);
        chk({active_out, led_out}, 2'h0);
        // Run once entered with the line low waits for the next rise
        host_u.cmd(4, 1'b0);
        hold(1'b0, 45);
        chk({active_out, led_out}, 2'h2);
        hold(1'b1, 10);
        chk({active_out, led_out}, 2'h3);
        hold(1'b0, 3);
        chk({active_out, led_out}, 2'h0);
    endtask
    // On time held past 255 units saturates and drops the LED
    task automatic s_sat();
        host_u.cmd(2, 1'b0);
        hold(1'b0, 45);
        hold(1'b1, 2600);
        chk({active_out, led_out}, 2'h2);
        hold(1'b0, 3);
        host_u.cmd(3, 1'b0);
        hold(1'b0, 45);
        chk({active_out, led_out}, 2'h0);
        chk(seq_len_out, 2'h1);
    endtask
    task automatic s_clear();
        host_u.cmd(2, 1'b0);
        hold(1'b0, 45);
        host_u.cmd(3, 1'b0);
        hold(1'b0, 45);
        chk(seq_len_out, 2'h0);
    endtask
    initial
    begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_fail++;
            summarize();
        end
    end
    initial
    begin
        rst_n_in = 1'b0;
        thermal_shutdown_in = 1'b0;
        repeat (3) @(posedge clock_in);
        #10;
        chk({active_out, led_out}, 2'h0);
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        hold(1'b0, 3);
        chk({active_out, seq_len_out[0]}, 2'h0);
        s_direct();
        s_train();
        s_play();
        s_sat();
        s_clear();
        summarize();
    end
endmodule
